// File: rtl/sefe_defines.vh
// Constants for the serial command front end of a small SPI EEPROM.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SEFE_DEFINES_VH
`define SEFE_DEFINES_VH
// Opcodes.
`define SEFE_OP_SET_LATCH    8'h06
`define SEFE_OP_CLR_LATCH    8'h04
`define SEFE_OP_STATUS_READ  8'h05
`define SEFE_OP_STATUS_WRITE 8'h01
`define SEFE_OP_MEM_READ     8'h03
`define SEFE_OP_MEM_WRITE    8'h02
// Status register bit positions.
`define SEFE_SR_PPEN   7
`define SEFE_SR_BPHI   3
`define SEFE_SR_BPLO   2
`define SEFE_SR_LATCH  1
`define SEFE_SR_BUSY   0
// Phase codes of the command state machine.
`define SEFE_PH_OPCODE 3'h0
`define SEFE_PH_ADDR   3'h1
`define SEFE_PH_DATA   3'h2
`define SEFE_PH_READ   3'h3
`define SEFE_PH_IGNORE 3'h4
// Write cycle time in microseconds and clock rate in kHz.
`define SEFE_TWC_US    5000
`define SEFE_CLK_KHZ   40000
// Address bits per memory address and bits per byte.
`define SEFE_ADDR_BITS 16
`define SEFE_BYTE_BITS 8
`endif

// File: rtl/sefe_sync.v
// Two-flop synchroniser with an edge detector on the synchronised level.
// Assumes the input is asynchronous to clk; first flop read only by second.
`timescale 1ns/100ps
module sefe_sync
#(
  parameter IDLE = 1'b0  // Pin level held in reset, so no false edge follows it.
)
(
  // Clock, reset and enable.
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  // Asynchronous level in.
  input  wire async_in,
  // Synchronised level and its edges.
  output reg  level_q,
  output wire rise,
  output wire fall
);
  reg meta_q;   // First stage, read only by the second.
  reg sync_q;   // Second stage.

  ////////////////////////////////////////////////////////////////////////////
  // Two stages and a delayed copy for edge detection.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q  <= IDLE;
      sync_q  <= IDLE;
      level_q <= IDLE;
    end
    else if (ce)
    begin
      meta_q  <= async_in;
      sync_q  <= meta_q;
      level_q <= sync_q;
    end
  end

  // Edges are one-cycle pulses, only valid while the enable is high.
  assign rise = ce & sync_q & ~level_q;
  assign fall = ce & ~sync_q & level_q;
endmodule // sefe_sync

// File: rtl/sefe_front_end.v
// Serial command front end of a small SPI EEPROM, on the system clock.
// Assumes pins arrive asynchronously; the memory array sits outside.
//
// Notes on behaviour
// - First byte after select is the opcode.
// - Input bits sampled on serial clock rising.
// - Output changes only on serial clock falling.
// - Latch set 06h, latch clear 04h.
// - Status read 05h, status write 01h.
// - Memory read 03h, memory write 02h.
// - Select high: output off, standby unless busy.
// - Write cycle starts on select rising.
// - Pin low and enable set block status write.
// - Pin high gives no protection.
// - Pin falling mid-sequence abandons status write.
// - Started status write completes regardless of pin.
// - Enable bit clear ignores the pin.
// - Clock idling high works the same.
// - Status bit 0 shows busy.
// - Latch set/cleared by opcodes, shown in status.
// - While busy only status read is obeyed.
// - Status bits 7, 3, 2, 1, 0 as placed.
`timescale 1ns/100ps
`include "sefe_defines.vh"
module sefe_front_end
#(
  parameter TWC_CYCLES = (`SEFE_TWC_US * (`SEFE_CLK_KHZ / 1000))  // Write time.
)
(
  // System clock, reset and enable.
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // Serial pins from the host.
  input  wire        sel_n,
  input  wire        sclk,
  input  wire        sdi,
  input  wire        wp_n,
  // Serial output pin as data and enable (enable low drives).
  output reg         sdo_o,
  output reg         sdo_oe_n,
  // Memory array side.
  output reg  [15:0] mem_addr,
  output reg         mem_rd,
  input  wire [7:0]  mem_rdata,
  output reg  [7:0]  mem_wdata,
  output reg         mem_wr,
  // Status and standby.
  output wire [7:0]  status,
  output wire        standby
);
  // Synchronised pins and their edges.
  wire sel_l, sel_rise, sel_fall;
  wire sck_l, sck_rise, sck_fall;
  wire sdi_l, wp_l;

  reg  [2:0]  phase_q;     // Command phase.
  reg  [7:0]  shift_q;     // Input shift register.
  reg  [4:0]  cnt_q;       // Bits taken in the current field.
  reg  [7:0]  op_q;        // Instruction register.
  reg  [7:0]  out_q;       // Output shift register.
  reg  [2:0]  ocnt_q;      // Bits left in output byte.
  reg         latch_q;     // Write-enable latch.
  reg         ppen_q;      // Protect-pin enable.
  reg  [1:0]  bp_q;        // Block-protect bits.
  reg  [7:0]  sr_new_q;    // Pending status write value.
  reg         sr_pend_q;   // Status write armed.
  reg         mem_pend_q;  // Memory write armed.
  reg         busy_q;      // Internal write cycle running.
  reg  [31:0] twc_q;       // Write cycle counter.
  reg         rd_armed_q;  // Cleared while deselected, never set or read; ocnt_q decides when a fresh byte loads.

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; the serial clock is sampled like any other pin.
  sefe_sync #(.IDLE(1'b1)) u_sel (.clk(clk), .rst_n(rst_n), .ce(ce), .async_in(sel_n),
                   .level_q(sel_l), .rise(sel_rise), .fall(sel_fall));
  sefe_sync u_sck (.clk(clk), .rst_n(rst_n), .ce(ce), .async_in(sclk),
                   .level_q(sck_l), .rise(sck_rise), .fall(sck_fall));
  sefe_sync u_sdi (.clk(clk), .rst_n(rst_n), .ce(ce), .async_in(sdi),
                   .level_q(sdi_l), .rise(), .fall());
  sefe_sync #(.IDLE(1'b1)) u_wp  (.clk(clk), .rst_n(rst_n), .ce(ce), .async_in(wp_n),
                   .level_q(wp_l), .rise(), .fall());

  // Hardware protection is active only with pin low and enable set.
  wire hw_prot = ppen_q & ~wp_l;
  wire [7:0] next_in = {shift_q[6:0], sdi_l};

  // Status image, reserved bits read zero.
  assign status = {ppen_q, 3'h0, bp_q, latch_q, busy_q};
  // Standby only while deselected and no write runs.
  assign standby = sel_l & ~busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command decoding and input shifting; the select and protect
  // synchronisers reset to their idle high level, so reset makes no edge.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_q    <= `SEFE_PH_IGNORE;
      shift_q    <= 8'h00;
      cnt_q      <= 5'h00;
      op_q       <= 8'h00;
      latch_q    <= 1'b0;
      ppen_q     <= 1'b0;
      bp_q       <= 2'h0;
      sr_new_q   <= 8'h00;
      sr_pend_q  <= 1'b0;
      mem_pend_q <= 1'b0;
      busy_q     <= 1'b0;
      twc_q      <= 32'h0;
      mem_addr   <= 16'h0000;
      mem_wdata  <= 8'h00;
      mem_wr     <= 1'b0;
      mem_rd     <= 1'b0;
    end
    else if (ce)
    begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      // Self-timed write period counts down and then frees the device.
      if (busy_q)
      begin
        if (twc_q <= 32'h1)
          busy_q <= 1'b0;
        else
          twc_q <= twc_q - 32'h1;
      end
      if (sel_fall)
      begin
        // Only a falling select opens a new sequence.
        phase_q <= `SEFE_PH_OPCODE;
        cnt_q   <= 5'h00;
      end
      else if (sel_rise)
      begin
        // Close the sequence; armed writes start here and not sooner.
        phase_q    <= `SEFE_PH_IGNORE;
        cnt_q      <= 5'h00;
        sr_pend_q  <= 1'b0;
        mem_pend_q <= 1'b0;
        if (sr_pend_q && !hw_prot)
        begin
          ppen_q  <= sr_new_q[`SEFE_SR_PPEN];
          bp_q    <= {sr_new_q[`SEFE_SR_BPHI], sr_new_q[`SEFE_SR_BPLO]};
          latch_q <= 1'b0;
          busy_q  <= 1'b1;
          twc_q   <= TWC_CYCLES;
        end
        else if (mem_pend_q)
        begin
          mem_wr  <= 1'b1;
          latch_q <= 1'b0;
          busy_q  <= 1'b1;
          twc_q   <= TWC_CYCLES;
        end
      end
      else if (!sel_l && sck_rise && phase_q != `SEFE_PH_IGNORE)
      begin
        // Every input bit is taken on a rising serial clock.
        shift_q <= next_in;
        cnt_q   <= cnt_q + 5'h01;
        case (phase_q)
          `SEFE_PH_OPCODE:
          begin
            if (cnt_q == 5'h07)
            begin
              op_q  <= next_in;
              cnt_q <= 5'h00;
              // Busy device obeys only the status read.
              if (busy_q && next_in != `SEFE_OP_STATUS_READ)
                phase_q <= `SEFE_PH_IGNORE;
              else
                case (next_in)
                  `SEFE_OP_SET_LATCH:    begin latch_q <= 1'b1; phase_q <= `SEFE_PH_IGNORE; end
                  `SEFE_OP_CLR_LATCH:    begin latch_q <= 1'b0; phase_q <= `SEFE_PH_IGNORE; end
                  `SEFE_OP_STATUS_READ:  phase_q <= `SEFE_PH_READ;
                  `SEFE_OP_STATUS_WRITE: phase_q <= `SEFE_PH_DATA;
                  `SEFE_OP_MEM_READ:     phase_q <= `SEFE_PH_ADDR;
                  `SEFE_OP_MEM_WRITE:    phase_q <= `SEFE_PH_ADDR;
                  default:               phase_q <= `SEFE_PH_IGNORE;
                endcase
            end
          end
          `SEFE_PH_ADDR:
          begin
            mem_addr <= {mem_addr[14:0], sdi_l};
            if (cnt_q == 5'h0f)
            begin
              cnt_q <= 5'h00;
              if (op_q == `SEFE_OP_MEM_READ)
              begin
                phase_q <= `SEFE_PH_READ;
                mem_rd  <= 1'b1;
              end
              else
                phase_q <= `SEFE_PH_DATA;
            end
          end
          `SEFE_PH_DATA:
          begin
            if (cnt_q == 5'h07)
            begin
              cnt_q   <= 5'h00;
              phase_q <= `SEFE_PH_IGNORE;
              // Writes need the latch; status writes also the pin.
              if (op_q == `SEFE_OP_STATUS_WRITE)
              begin
                sr_new_q  <= next_in;
                sr_pend_q <= latch_q & ~hw_prot;
              end
              else
              begin
                mem_wdata  <= next_in;
                mem_pend_q <= latch_q;
              end
            end
          end
          default:
          begin
            // Memory reads advance the address per byte for sequential reads.
            if (cnt_q == 5'h07 && op_q == `SEFE_OP_MEM_READ)
            begin
              cnt_q    <= 5'h00;
              mem_addr <= mem_addr + 16'h0001;
              mem_rd   <= 1'b1;
            end
            else if (cnt_q == 5'h07)
              cnt_q <= 5'h00;
          end
        endcase
      end
      // A pin fall while selected, with the enable bit set, cancels a pending status write.
      if (!sel_l && !sel_rise && hw_prot && sr_pend_q)
        sr_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter: loads and shifts only on a falling serial clock, so the
  // first bit appears after the first falling edge following the opcode, or the address for a memory read.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_q      <= 8'h00;
      ocnt_q     <= 3'h0;
      rd_armed_q <= 1'b0;
      sdo_o      <= 1'b0;
      sdo_oe_n   <= 1'b1;
    end
    else if (ce)
    begin
      if (sel_l)
      begin
        sdo_oe_n   <= 1'b1;
        rd_armed_q <= 1'b0;
        ocnt_q     <= 3'h0;
      end
      else if (phase_q == `SEFE_PH_READ && sck_fall)
      begin
        sdo_oe_n <= 1'b0;
        if (ocnt_q == 3'h0)
        begin
          // Load a fresh byte and present its top bit.
          if (op_q == `SEFE_OP_MEM_READ)
          begin
            sdo_o <= mem_rdata[7];
            out_q <= {mem_rdata[6:0], 1'b0};
          end
          else
          begin
            sdo_o <= status[7];
            out_q <= {status[6:0], 1'b0};
          end
          ocnt_q <= 3'h7;
        end
        else
        begin
          sdo_o  <= out_q[7];
          out_q  <= {out_q[6:0], 1'b0};
          ocnt_q <= ocnt_q - 3'h1;
        end
      end
    end
  end
endmodule // sefe_front_end

// File: tb/sefe_checker.sv
// Port checker for the serial front end.
// Assumes the bind below and one clock domain.
`timescale 1ns/100ps
module sefe_checker
#(
  parameter TWC_CYCLES = 20  // Busy length.
)
(
  // Clock and reset.
  input wire       clk,
  input wire       rst_n,
  // Pins and status.
  input wire       sel_n,
  input wire       sclk,
  input wire       sdo_o,
  input wire       sdo_oe_n,
  input wire       mem_wr,
  input wire [7:0] status,
  input wire       standby
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Counts the cycles of the running busy period.
  reg [31:0] busy_q;
  always @(posedge clk)
    busy_q <= (rst_n && status[0]) ? busy_q + 1 : 32'h0;
  ////////////////////////////////////////////////////////////
  AST_OFF:
    assert property (sel_n [*5] |-> sdo_oe_n) else $error("sdo driven while deselected");
  AST_FALL:
    assert property ($changed(sdo_o) && !sdo_oe_n |-> !$past(sclk, 2) || !$past(sclk, 3)
      || !$past(sclk, 4)) else $error("sdo moved without a falling clock");
  AST_TWC:
    assert property ($fell(status[0]) |-> busy_q == TWC_CYCLES) else $error("busy length wrong");
  AST_WRSEL:
    assert property (mem_wr |-> sel_n && $past(sel_n, 2)) else $error("write before select rose");
  AST_WRBUSY:
    assert property (mem_wr |-> ##[0:2] status[0]) else $error("write without busy");
  AST_PULSE:
    assert property (mem_wr |=> !mem_wr) else $error("write pulse too long");
  AST_SBY:
    assert property (status[0] |-> !standby) else $error("standby while busy");
  AST_IGN:
    assert property ($rose(status[1]) |-> !$past(status[0])) else $error("latch set while busy");
endmodule // sefe_checker
bind sefe_front_end sefe_checker #(.TWC_CYCLES(TWC_CYCLES)) chk (.clk, .rst_n, .sel_n, .sclk,
  .sdo_o, .sdo_oe_n, .mem_wr, .status, .standby);

// File: tb/sefe_host.sv
// Host side of the serial link: select, clock, data.
// Assumes a 25 ns system clock; 8 clocks per serial bit.
`timescale 1ns/100ps
module sefe_host
(
  // System clock and the device's output.
  input wire clk,
  input wire sdo_o,
  input wire sdo_oe_n,
  // Pins driven towards the device.
  output reg sel_n,
  output reg sclk,
  output reg sdi
);
  reg idle_hi = 1'b0;  // Clock level between frames.
  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task wait_clk(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Clock mode 0,0 or 1,1, switched only while deselected.
  task set_mode(input m);
    @(posedge clk);
    idle_hi <= m;
    sclk <= m;
    wait_clk(8);
  endtask
  // Every frame opens with a falling select.
  task start;
    @(posedge clk);
    sel_n <= 1'b0;
    wait_clk(4);
  endtask
  // One byte each way, MSB first; sampled late, so slow output still lands.
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
    begin
      sclk <= 1'b0;
      sdi <= tx[i];
      wait_clk(4);
      sclk <= 1'b1;
      wait_clk(4);
      rx[i] = sdo_oe_n ? ~sdo_o : sdo_o;
    end
  endtask
  // Closes the frame; data line is not left at its last value.
  task stop;
    @(posedge clk);
    sclk <= idle_hi;
    sdi <= ~sdi;
    wait_clk(2);
    sel_n <= 1'b1;
    wait_clk(10);
  endtask
endmodule // sefe_host

// File: tb/spi_eeprom_command_front_end_tb.sv
// Testbench: command sequences with expected results.
// Assumes the host model and checker files compile first.
`timescale 1ns/100ps
`include "sefe_defines.vh"
module spi_eeprom_command_front_end_tb;
  localparam TWC = 400;  // Short write time keeps the run brief.
  localparam integer powerup_read_delay = 40000;  // 1 ms in 25 ns clock cycles.
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        wp_n = 1'b1;
  reg  [7:0] mem_rdata = 8'h00;
  wire       sel_n, sclk, sdi, sdo_o, sdo_oe_n, mem_rd, mem_wr, standby;
  wire [15:0] mem_addr;
  wire [7:0] mem_wdata, status;
  reg  [7:0] rx;
  reg  [15:0] wr_addr;
  reg  [7:0] wr_data;
  integer    wr_cnt = 0, mismatches = 0, n_compared = 0, i;
  always #12.5 clk = ~clk;
  sefe_front_end #(.TWC_CYCLES(TWC)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .sel_n(sel_n),
    .sclk(sclk), .sdi(sdi), .wp_n(wp_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .status(status), .standby(standby));
  sefe_host host (.clk(clk), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sel_n(sel_n), .sclk(sclk),
    .sdi(sdi));
  ////////////////////////////////////////////////////////////
  // Array stand-in: read data is latched per request so increments cannot race it.
  always @(posedge clk)
  begin
    if (mem_rd)
      mem_rdata <= mem_addr[7:0] ^ 8'h5a;
    if (mem_wr)
    begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  task chk(input [63:0] what, input [15:0] seen, input [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  task cmd(input [7:0] op);
    host.start;
    host.xfer(op, rx);
    host.stop;
  endtask
  task rd_sr(output [7:0] v);
    host.start;
    host.xfer(`SEFE_OP_STATUS_READ, rx);
    host.xfer(8'h00, v);
    host.stop;
  endtask
  // Opcode, 16-bit address, one data byte.
  task mem_cmd(input [7:0] op, input [15:0] a, input [7:0] d, output [7:0] v);
    host.start;
    host.xfer(op, rx);
    host.xfer(a[15:8], rx);
    host.xfer(a[7:0], rx);
    host.xfer(d, v);
    host.stop;
  endtask
  task wait_ready;
    for (i = 0; status[0] !== 1'b0 && i < 2000; i = i + 1)
      @(posedge clk);
    chk("ready", i < 2000, 1);
  endtask
  // Status write with the pin set before; mode 1 pulses the pin low after
  // the data byte and back high before select rises, mode 2 drops it once
  // the write cycle has started.
  task sr_case(input [7:0] d, input wp, input [1:0] mid, input [7:0] exp);
    wp_n <= wp;
    cmd(`SEFE_OP_SET_LATCH);
    host.start;
    host.xfer(`SEFE_OP_STATUS_WRITE, rx);
    host.xfer(d, rx);
    if (mid == 2'h1)
    begin
      wp_n <= 1'b0;
      host.wait_clk(6);
      wp_n <= 1'b1;
      host.wait_clk(6);
    end
    host.stop;
    if (mid == 2'h2)
      wp_n <= 1'b0;
    wait_ready;
    rd_sr(rx);
    chk("sr_bits", rx & 8'hfc, exp);
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    host.wait_clk(2);
    rst_n <= 1'b1;
    // No read is issued before the power-up delay has run out.
    host.wait_clk(powerup_read_delay);
    rd_sr(rx);
    chk("sr_init", rx, 8'h00);
    chk("standby", standby, 1'b1);
    chk("sdo_off", sdo_oe_n, 1'b1);
    cmd(`SEFE_OP_SET_LATCH);
    rd_sr(rx);
    chk("latch", rx, 8'h02);
    cmd(`SEFE_OP_CLR_LATCH);
    rd_sr(rx);
    chk("unlatch", rx, 8'h00);
    cmd(`SEFE_OP_SET_LATCH);
    mem_cmd(`SEFE_OP_MEM_WRITE, 16'h1234, 8'ha5, rx);
    chk("wr_cnt", wr_cnt[15:0], 1);
    chk("wr_addr", wr_addr, 16'h1234);
    chk("wr_data", wr_data, 8'ha5);
    rd_sr(rx);
    chk("busy", rx, 8'h01);
    cmd(`SEFE_OP_SET_LATCH);
    wait_ready;
    rd_sr(rx);
    chk("ignored", rx, 8'h00);
    mem_cmd(`SEFE_OP_MEM_READ, 16'h0010, 8'h00, rx);
    chk("rd_data", rx, 8'h4a);
    host.set_mode(1'b1);
    rd_sr(rx);
    chk("mode11", rx, 8'h00);
    sr_case(8'h8c, 1'b1, 2'h0, 8'h8c);
    sr_case(8'h00, 1'b0, 2'h0, 8'h8c);
    sr_case(8'h00, 1'b1, 2'h1, 8'h8c);
    sr_case(8'h84, 1'b1, 2'h2, 8'h84);
    sr_case(8'h04, 1'b1, 2'h0, 8'h04);
    sr_case(8'h08, 1'b0, 2'h0, 8'h08);
    finish_test;
  end
  // Watchdog well past the expected run length.
  initial
  begin
    #2000000;
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule // spi_eeprom_command_front_end_tb
